// file: ovsr_pkg.sv
// package for the output voltage setpoint register bank
// shared command codes, reset values and field positions
package ovsr_pkg;
	// command codes of the bank and its neighbours
	localparam logic [7:0] CMD_PAGE = 8'h00;
	localparam logic [7:0] CMD_OPERATION = 8'h01;
	localparam logic [7:0] CMD_FORMAT = 8'h20;
	localparam logic [7:0] CMD_NOMINAL = 8'h21;
	localparam logic [7:0] CMD_OFFSET = 8'h22;
	localparam logic [7:0] CMD_CEILING = 8'h24;
	localparam logic [7:0] CMD_UPPER = 8'h25;
	localparam logic [7:0] CMD_LOWER = 8'h26;
	localparam logic [7:0] CMD_SLEW = 8'h27;
	localparam logic [7:0] CMD_SLOPE = 8'h28;
	localparam logic [7:0] CMD_APPLY = 8'he7;
	// reset values
	localparam logic [7:0] RST_FORMAT = 8'h40;
	localparam logic [15:0] RST_NOMINAL = 16'h0384;
	localparam logic [15:0] RST_OFFSET = 16'h0000;
	localparam logic [15:0] RST_CEILING = 16'h08fc;
	localparam logic [15:0] RST_UPPER = 16'h0640;
	localparam logic [15:0] RST_LOWER = 16'h00fa;
	localparam logic [15:0] RST_SLEW = 16'h0064;
	localparam logic [15:0] RST_SLOPE = 16'h0000;
	localparam logic [7:0] RST_PAGE = 8'h00;
	localparam logic [7:0] RST_OPERATION = 8'h08;
	// page selections
	localparam logic [7:0] PAGE_OUT0 = 8'h00;
	localparam logic [7:0] PAGE_OUT1 = 8'h01;
	localparam logic [7:0] PAGE_BOTH = 8'hff;
	// source field of the operation control
	localparam int SRC_LSB = 4;
	localparam logic [1:0] SRC_NOMINAL = 2'h0;
	localparam logic [1:0] SRC_LOWER = 2'h1;
	localparam logic [1:0] SRC_UPPER = 2'h2;
	// trim bound in millivolts
	localparam logic signed [17:0] TRIM_LIMIT_MV = 18'sd250;
endpackage

// file: ovsr_regs.sv
// output voltage setpoint registers, two outputs, paged access
// assumes a decoded command port: one-cycle write or read strobes
`timescale 1ns/1ns

// Summary of operation
// - format query reads fixed 40h
// - paged 16-bit values kept per output
// - nominal setpoint, reset 0384h, nominal target
// - signed trim, reset 0, within 250 mV
// - ceiling, reset 08FCh, target never above
// - margin-high setpoint, reset 0640h
// - margin-low setpoint, reset 00FAh
// - slew rate, reset 0064h, times 100
// - droop slope, reset 0, times 10
// - slew and droop act only after apply
// - page picks output 0, 1 or both
// - source field picks nominal, low, high
module ovsr_regs #(
	parameter int NOUT = 2
) (
	input wire logic CORE_CLK,
	input wire logic SRST,
	input wire logic WR_EN,
	input wire logic RD_EN,
	input wire logic [7:0] CMD,
	input wire logic [15:0] WDATA,
	output logic [15:0] RDATA,
	output logic RD_VALID,
	output logic [15:0] TARGET_MV_0,
	output logic [15:0] TARGET_MV_1,
	output logic [15:0] SLEW_ACTIVE_0,
	output logic [15:0] SLEW_ACTIVE_1,
	output logic [15:0] SLOPE_ACTIVE_0,
	output logic [15:0] SLOPE_ACTIVE_1
);
	typedef logic [15:0] ovsr_word_t;

	// page decode used by writes only; reads pick output 1 on page 01, else output 0
	function automatic logic page_hits(input logic [7:0] pg, input int idx);
		page_hits = (pg == ovsr_pkg::PAGE_BOTH) ||
			(pg[3:0] == 4'(idx) && pg[7:4] == 4'h0);
	endfunction

	logic [7:0] page_ff, nxt_page;
	logic [7:0] oper_ff, nxt_oper;
	ovsr_word_t nom_ff [NOUT], nxt_nom [NOUT];
	ovsr_word_t trim_ff [NOUT], nxt_trim [NOUT];
	ovsr_word_t ceil_ff [NOUT], nxt_ceil [NOUT];
	ovsr_word_t hi_ff [NOUT], nxt_hi [NOUT];
	ovsr_word_t lo_ff [NOUT], nxt_lo [NOUT];
	ovsr_word_t slew_ff [NOUT], nxt_slew [NOUT];
	ovsr_word_t slope_ff [NOUT], nxt_slope [NOUT];
	ovsr_word_t slew_act_ff [NOUT], nxt_slew_act [NOUT];
	ovsr_word_t slope_act_ff [NOUT], nxt_slope_act [NOUT];
	ovsr_word_t tgt_ff [NOUT], nxt_tgt [NOUT];
	ovsr_word_t rdata_ff, nxt_rdata;
	logic rdv_ff, nxt_rdv;
	logic apply_hit;
	logic page_ok;

	assign apply_hit = WR_EN && CMD == ovsr_pkg::CMD_APPLY;
	// writes to an undefined page value are dropped
	assign page_ok = page_ff == ovsr_pkg::PAGE_OUT0 ||
		page_ff == ovsr_pkg::PAGE_OUT1 || page_ff == ovsr_pkg::PAGE_BOTH;

	// global page and operation control
	always_comb begin
		nxt_page = page_ff;
		nxt_oper = oper_ff;
		if (WR_EN && CMD == ovsr_pkg::CMD_PAGE) begin
			nxt_page = WDATA[7:0];
		end
		if (WR_EN && CMD == ovsr_pkg::CMD_OPERATION) begin
			nxt_oper = WDATA[7:0];
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			page_ff <= ovsr_pkg::RST_PAGE;
			oper_ff <= ovsr_pkg::RST_OPERATION;
		end else begin
			page_ff <= nxt_page;
			oper_ff <= nxt_oper;
		end
	end

	// per-output storage, one copy per page
	for (genvar g = 0; g < NOUT; g++) begin : g_out
		logic sel;
		logic signed [17:0] trim_s;
		logic signed [17:0] sum_s;
		logic [15:0] src;
		assign sel = WR_EN && page_ok && page_hits(page_ff, g);

		always_comb begin
			nxt_nom[g] = nom_ff[g];
			nxt_trim[g] = trim_ff[g];
			nxt_ceil[g] = ceil_ff[g];
			nxt_hi[g] = hi_ff[g];
			nxt_lo[g] = lo_ff[g];
			nxt_slew[g] = slew_ff[g];
			nxt_slope[g] = slope_ff[g];
			nxt_slew_act[g] = slew_act_ff[g];
			nxt_slope_act[g] = slope_act_ff[g];
			if (sel) begin
				case (CMD)
					ovsr_pkg::CMD_NOMINAL: nxt_nom[g] = WDATA;
					ovsr_pkg::CMD_OFFSET: nxt_trim[g] = WDATA;
					ovsr_pkg::CMD_CEILING: nxt_ceil[g] = WDATA;
					ovsr_pkg::CMD_UPPER: nxt_hi[g] = WDATA;
					ovsr_pkg::CMD_LOWER: nxt_lo[g] = WDATA;
					ovsr_pkg::CMD_SLEW: nxt_slew[g] = WDATA;
					ovsr_pkg::CMD_SLOPE: nxt_slope[g] = WDATA;
					default: ;
				endcase
			end
			// staged values commit only on apply, to every output
			if (apply_hit) begin
				nxt_slew_act[g] = slew_ff[g];
				nxt_slope_act[g] = slope_ff[g];
			end
			// target built from next values so it moves with its
			// registers; a lagging target could sit above a new ceiling
			trim_s = 18'(signed'(nxt_trim[g]));
			// clamp trim so a bad write cannot exceed the bound
			if (trim_s > ovsr_pkg::TRIM_LIMIT_MV) begin
				trim_s = ovsr_pkg::TRIM_LIMIT_MV;
			end else if (trim_s < -ovsr_pkg::TRIM_LIMIT_MV) begin
				trim_s = -ovsr_pkg::TRIM_LIMIT_MV;
			end
			case (nxt_oper[ovsr_pkg::SRC_LSB +: 2])
				ovsr_pkg::SRC_LOWER: src = nxt_lo[g];
				ovsr_pkg::SRC_UPPER: src = nxt_hi[g];
				default: src = nxt_nom[g];
			endcase
			sum_s = 18'(signed'({2'b00, src})) + trim_s;
			if (sum_s < 18'sd0) begin
				nxt_tgt[g] = 16'h0000;
			end else if (sum_s > 18'(signed'({2'b00, nxt_ceil[g]}))) begin
				nxt_tgt[g] = nxt_ceil[g];
			end else begin
				nxt_tgt[g] = sum_s[15:0];
			end
		end

		always_ff @(posedge CORE_CLK) begin
			if (SRST) begin
				nom_ff[g] <= ovsr_pkg::RST_NOMINAL;
				trim_ff[g] <= ovsr_pkg::RST_OFFSET;
				ceil_ff[g] <= ovsr_pkg::RST_CEILING;
				hi_ff[g] <= ovsr_pkg::RST_UPPER;
				lo_ff[g] <= ovsr_pkg::RST_LOWER;
				slew_ff[g] <= ovsr_pkg::RST_SLEW;
				slope_ff[g] <= ovsr_pkg::RST_SLOPE;
				slew_act_ff[g] <= ovsr_pkg::RST_SLEW;
				slope_act_ff[g] <= ovsr_pkg::RST_SLOPE;
				tgt_ff[g] <= ovsr_pkg::RST_NOMINAL; // no trim, below ceiling
			end else begin
				nom_ff[g] <= nxt_nom[g];
				trim_ff[g] <= nxt_trim[g];
				ceil_ff[g] <= nxt_ceil[g];
				hi_ff[g] <= nxt_hi[g];
				lo_ff[g] <= nxt_lo[g];
				slew_ff[g] <= nxt_slew[g];
				slope_ff[g] <= nxt_slope[g];
				slew_act_ff[g] <= nxt_slew_act[g];
				slope_act_ff[g] <= nxt_slope_act[g];
				tgt_ff[g] <= nxt_tgt[g];
			end
		end
	end

	// read mux; page both reads output 0, undefined page reads zero
	always_comb begin
		logic [0:0] ix;
		ix = 1'(page_ff == ovsr_pkg::PAGE_OUT1);
		nxt_rdv = RD_EN;
		nxt_rdata = rdata_ff;
		if (RD_EN) begin
			nxt_rdata = 16'h0000;
			case (CMD)
				ovsr_pkg::CMD_PAGE: nxt_rdata = {8'h00, page_ff};
				ovsr_pkg::CMD_OPERATION: nxt_rdata = {8'h00, oper_ff};
				ovsr_pkg::CMD_FORMAT:
					nxt_rdata = {8'h00, ovsr_pkg::RST_FORMAT};
				default: begin
					if (page_ok) begin
						case (CMD)
							ovsr_pkg::CMD_NOMINAL: nxt_rdata = nom_ff[ix];
							ovsr_pkg::CMD_OFFSET: nxt_rdata = trim_ff[ix];
							ovsr_pkg::CMD_CEILING: nxt_rdata = ceil_ff[ix];
							ovsr_pkg::CMD_UPPER: nxt_rdata = hi_ff[ix];
							ovsr_pkg::CMD_LOWER: nxt_rdata = lo_ff[ix];
							ovsr_pkg::CMD_SLEW: nxt_rdata = slew_ff[ix];
							ovsr_pkg::CMD_SLOPE: nxt_rdata = slope_ff[ix];
							default: nxt_rdata = 16'h0000;
						endcase
					end
				end
			endcase
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			rdata_ff <= 16'h0000;
			rdv_ff <= 1'b0;
		end else begin
			rdata_ff <= nxt_rdata;
			rdv_ff <= nxt_rdv;
		end
	end

	assign RDATA = rdata_ff;
	assign RD_VALID = rdv_ff;
	assign TARGET_MV_0 = tgt_ff[0];
	assign TARGET_MV_1 = tgt_ff[NOUT-1];
	assign SLEW_ACTIVE_0 = slew_act_ff[0];
	assign SLEW_ACTIVE_1 = slew_act_ff[NOUT-1];
	assign SLOPE_ACTIVE_0 = slope_act_ff[0];
	assign SLOPE_ACTIVE_1 = slope_act_ff[NOUT-1];

	// checks
	format_read_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
		RD_EN && CMD == ovsr_pkg::CMD_FORMAT |=> RDATA == 16'h0040 && RD_VALID)
		else $error("format query wrong");
	target_cap_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
		TARGET_MV_0 <= ceil_ff[0])
		else $error("target above ceiling");
	slew_hold_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
		!apply_hit |=> $stable(SLEW_ACTIVE_0))
		else $error("slew moved without apply");
	slope_hold_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
		!apply_hit |=> $stable(SLOPE_ACTIVE_1))
		else $error("droop moved without apply");
	apply_take_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
		apply_hit |=> SLEW_ACTIVE_1 == $past(slew_ff[1]))
		else $error("apply not taken");
	nom_write_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
		WR_EN && CMD == ovsr_pkg::CMD_NOMINAL && page_ff == 8'h01
		|=> nom_ff[0] == $past(nom_ff[0]) && nom_ff[1] == $past(WDATA))
		else $error("page 1 write misrouted");
	both_write_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
		WR_EN && CMD == ovsr_pkg::CMD_UPPER && page_ff == 8'hff
		|=> hi_ff[0] == $past(WDATA) && hi_ff[1] == $past(WDATA))
		else $error("both-page write missed");
	// target selection: the target moves on the edge its inputs do
	src_low_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
		oper_ff[ovsr_pkg::SRC_LSB +: 2] == ovsr_pkg::SRC_LOWER
		&& trim_ff[0] == 16'h0000 && lo_ff[0] <= ceil_ff[0]
		|-> TARGET_MV_0 == lo_ff[0])
		else $error("margin low not selected");
	src_high_a: assert property (@(posedge CORE_CLK)
		disable iff (SRST)
		oper_ff[ovsr_pkg::SRC_LSB +: 2] == ovsr_pkg::SRC_UPPER
		&& trim_ff[0] == 16'h0000 && hi_ff[0] <= ceil_ff[0]
		|-> TARGET_MV_0 == hi_ff[0])
		else $error("margin high not selected");
	src_nom_a: assert property (@(posedge CORE_CLK)
		disable iff (SRST)
		oper_ff[ovsr_pkg::SRC_LSB +: 2] == ovsr_pkg::SRC_NOMINAL
		&& trim_ff[1] == 16'h0000 && nom_ff[1] <= ceil_ff[1]
		|-> TARGET_MV_1 == nom_ff[1])
		else $error("nominal not selected");
	// trim may move the target at most its bound from the setpoint
	trim_up_a: assert property (@(posedge CORE_CLK)
		disable iff (SRST)
		oper_ff[ovsr_pkg::SRC_LSB +: 2] == ovsr_pkg::SRC_NOMINAL
		|-> 18'(TARGET_MV_0) <= 18'(nom_ff[0]) + 18'(ovsr_pkg::TRIM_LIMIT_MV))
		else $error("trim above its bound");
	trim_down_a: assert property (@(posedge CORE_CLK)
		disable iff (SRST)
		oper_ff[ovsr_pkg::SRC_LSB +: 2] == ovsr_pkg::SRC_NOMINAL
		&& nom_ff[0] <= ceil_ff[0]
		|-> 18'(TARGET_MV_0) + 18'(ovsr_pkg::TRIM_LIMIT_MV) >= 18'(nom_ff[0]))
		else $error("trim below its bound");
	cap_out1_a: assert property (@(posedge CORE_CLK)
		disable iff (SRST)
		TARGET_MV_1 <= ceil_ff[NOUT-1])
		else $error("second target above ceiling");
	// page routing of stores
	page0_write_a: assert property (@(posedge CORE_CLK)
		disable iff (SRST)
		WR_EN && CMD == ovsr_pkg::CMD_OFFSET && page_ff == ovsr_pkg::PAGE_OUT0
		|=> trim_ff[0] == $past(WDATA) && trim_ff[1] == $past(trim_ff[1]))
		else $error("page 0 write misrouted");
	bad_page_a: assert property (@(posedge CORE_CLK)
		disable iff (SRST)
		WR_EN && !page_ok |=> $stable(nom_ff[0]) && $stable(nom_ff[1]))
		else $error("write stored under bad page");
	// staged values reach the active copies only through apply
	slope_take_a: assert property (@(posedge CORE_CLK)
		disable iff (SRST)
		apply_hit |=> SLOPE_ACTIVE_1 == $past(slope_ff[NOUT-1]))
		else $error("droop apply not taken");
	slew_hold1_a: assert property (@(posedge CORE_CLK)
		disable iff (SRST)
		!apply_hit |=> $stable(SLEW_ACTIVE_1))
		else $error("second slew moved without apply");
	slope_hold0_a: assert property (@(posedge CORE_CLK)
		disable iff (SRST)
		!apply_hit |=> $stable(SLOPE_ACTIVE_0))
		else $error("first droop moved without apply");
endmodule

// file: ovsr_host.sv
// host model: issues decoded register writes and reads
// assumes the bank takes strobes on the rising clock edge
`timescale 1ns/1ns
module ovsr_host (
	input wire logic CORE_CLK,
	input wire logic [15:0] RDATA,
	input wire logic RD_VALID,
	output logic WR_EN,
	output logic RD_EN,
	output logic [7:0] CMD,
	output logic [15:0] WDATA
);
	// idle bus carries junk, never a stale value
	initial begin
		WR_EN = 1'b0;
		RD_EN = 1'b0;
		CMD = 8'h5a;
		WDATA = 16'ha5a5;
	end
	// one strobe held over one taking edge
	task automatic wr(input logic [7:0] c, input logic [15:0] d);
		@(posedge CORE_CLK);
		#1;
		WR_EN = 1'b1;
		CMD = c;
		WDATA = d;
		@(posedge CORE_CLK);
		#1;
		WR_EN = 1'b0;
		CMD = ~c;
		WDATA = ~d;
	endtask
	// valid stands for one cycle after the taking edge; the data holds until the next read
	task automatic rd(input logic [7:0] c, output logic [15:0] d,
		output logic v);
		@(posedge CORE_CLK);
		#1;
		RD_EN = 1'b1;
		CMD = c;
		@(posedge CORE_CLK);
		#1;
		RD_EN = 1'b0;
		CMD = ~c;
		d = RDATA;
		v = RD_VALID;
	endtask
	// page select, byte in low half
	task automatic sel(input logic [7:0] p);
		wr(ovsr_pkg::CMD_PAGE, {8'h00, p});
	endtask
	// commit staged slew and droop, data ignored
	task automatic apply();
		wr(ovsr_pkg::CMD_APPLY, 16'h0000);
	endtask
endmodule

// file: tb.sv
// testbench for the setpoint register bank
// assumes one 20 MHz clock and the host model beside it
`timescale 1ns/1ns
module tb;
	logic clk;
	logic srst;
	logic wr_en, rd_en, rd_valid;
	logic [7:0] cmd;
	logic [15:0] wdata, rdata, t0, t1, s0, s1, d0, d1;
	int fail_count = 0;
	int checks_done = 0;
	// 50 ns clock
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	ovsr_regs ovsr_regs_inst (.CORE_CLK(clk), .SRST(srst), .WR_EN(wr_en),
		.RD_EN(rd_en), .CMD(cmd), .WDATA(wdata), .RDATA(rdata),
		.RD_VALID(rd_valid), .TARGET_MV_0(t0), .TARGET_MV_1(t1),
		.SLEW_ACTIVE_0(s0), .SLEW_ACTIVE_1(s1), .SLOPE_ACTIVE_0(d0),
		.SLOPE_ACTIVE_1(d1));
	ovsr_host ovsr_host_inst (.CORE_CLK(clk), .RDATA(rdata),
		.RD_VALID(rd_valid), .WR_EN(wr_en), .RD_EN(rd_en), .CMD(cmd),
		.WDATA(wdata));
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		checks_done++;
		if (g !== e) begin
			fail_count++;
			$display("wrong value at %0t: got %h want %h", $time, g, e);
		end
	endtask
	// read and judge the strobe echo as well as the data
	task automatic rchk(input logic [7:0] c, input logic [15:0] e);
		logic [15:0] d;
		logic v;
		ovsr_host_inst.rd(c, d, v);
		chk({15'h0000, v}, 16'h0001);
		chk(d, e);
	endtask
	task automatic w(input logic [7:0] c, input logic [15:0] d);
		ovsr_host_inst.wr(c, d);
	endtask
	// one spare edge before the targets are looked at
	task automatic settle();
		@(posedge clk);
		#1;
	endtask
	task automatic t_reset();
		rchk(ovsr_pkg::CMD_FORMAT, 16'h0040);
		rchk(ovsr_pkg::CMD_NOMINAL, 16'h0384);
		rchk(ovsr_pkg::CMD_OFFSET, 16'h0000);
		rchk(ovsr_pkg::CMD_CEILING, 16'h08fc);
		rchk(ovsr_pkg::CMD_UPPER, 16'h0640);
		rchk(ovsr_pkg::CMD_LOWER, 16'h00fa);
		rchk(ovsr_pkg::CMD_SLEW, 16'h0064);
		rchk(ovsr_pkg::CMD_SLOPE, 16'h0000);
		chk(t0, 16'h0384);
		chk(s1, 16'h0064);
	endtask
	task automatic t_page();
		w(ovsr_pkg::CMD_FORMAT, 16'h0011);
		rchk(ovsr_pkg::CMD_FORMAT, 16'h0040);
		ovsr_host_inst.sel(8'h01);
		w(ovsr_pkg::CMD_NOMINAL, 16'h0500);
		settle();
		chk(t1, 16'h0500);
		chk(t0, 16'h0384);
		ovsr_host_inst.sel(8'hff);
		w(ovsr_pkg::CMD_NOMINAL, 16'h0300);
		settle();
		chk(t0, 16'h0300);
		chk(t1, 16'h0300);
		// an unlisted page must neither store nor read back
		ovsr_host_inst.sel(8'h02);
		w(ovsr_pkg::CMD_NOMINAL, 16'h0123);
		rchk(ovsr_pkg::CMD_NOMINAL, 16'h0000);
		ovsr_host_inst.sel(8'h00);
		rchk(ovsr_pkg::CMD_NOMINAL, 16'h0300);
	endtask
	task automatic t_target();
		w(ovsr_pkg::CMD_OPERATION, 16'h0018);
		settle();
		chk(t0, 16'h00fa);
		w(ovsr_pkg::CMD_OPERATION, 16'h0028);
		settle();
		chk(t0, 16'h0640);
		w(ovsr_pkg::CMD_OPERATION, 16'h0008);
		w(ovsr_pkg::CMD_OFFSET, 16'h0064);
		settle();
		chk(t0, 16'h0364);
		w(ovsr_pkg::CMD_OFFSET, 16'h0190);
		settle();
		chk(t0, 16'h03fa);
		w(ovsr_pkg::CMD_OFFSET, 16'hff38);
		settle();
		chk(t0, 16'h0238);
		chk(t1, 16'h0300);
		w(ovsr_pkg::CMD_CEILING, 16'h0250);
		w(ovsr_pkg::CMD_OPERATION, 16'h0028);
		settle();
		chk(t0, 16'h0250);
		rchk(ovsr_pkg::CMD_OFFSET, 16'hff38);
		// unused source code falls back to the nominal setpoint
		w(ovsr_pkg::CMD_OPERATION, 16'h0038);
		settle();
		chk(t0, 16'h0238);
		rchk(ovsr_pkg::CMD_OPERATION, 16'h0038);
	endtask
	task automatic t_apply();
		ovsr_host_inst.sel(8'h01);
		w(ovsr_pkg::CMD_SLEW, 16'h0010);
		w(ovsr_pkg::CMD_SLOPE, 16'h0020);
		settle();
		chk(s1, 16'h0064);
		chk(d1, 16'h0000);
		rchk(ovsr_pkg::CMD_SLEW, 16'h0010);
		ovsr_host_inst.apply();
		settle();
		chk(s1, 16'h0010);
		chk(d1, 16'h0020);
		chk(s0, 16'h0064);
		chk(d0, 16'h0000);
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// cut a hang well beyond the hundred or so cycles needed
	initial begin
		#100000;
		fail_count++;
		results();
	end
	initial begin
		srst = 1'b1;
		repeat (16) @(posedge clk);
		#1;
		srst = 1'b0;
		t_reset();
		t_page();
		t_target();
		t_apply();
		results();
	end
endmodule
